// ---- rtl/pmra_pkg.sv ----
// Constants, types and register map of the power monitor result/alert block
package pmra_pkg;

    localparam logic [7:0]  ADDR_BUS     = 8'h02;
    localparam logic [7:0]  ADDR_POWER   = 8'h03;
    localparam logic [7:0]  ADDR_CURRENT = 8'h04;
    localparam logic [7:0]  ADDR_CAL     = 8'h05;
    localparam logic [7:0]  ADDR_MASK    = 8'h06;
    localparam logic [7:0]  ADDR_LIMIT   = 8'h07;

    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [14:0] CAL_RESET    = 15'h0000;
    localparam logic [4:0]  LIM_RESET    = 5'h00;

    // Mask register field positions
    localparam int LIM_HI    = 15;
    localparam int LIM_LO    = 11;
    localparam int DONE_ALERT_BIT  = 10;
    localparam int SRC_FLAG_BIT    = 4;
    localparam int DONE_FLAG_BIT   = 3;
    localparam int OVF_BIT         = 2;
    localparam int SENSE_SEL_BIT   = 1;
    localparam int HOLD_SEL_BIT    = 0;

    // Positions inside the five-bit limit enable field
    localparam int SENSE_OVER_IDX  = 4;
    localparam int SENSE_UNDER_IDX = 3;
    localparam int RAIL_OVER_IDX   = 2;
    localparam int RAIL_UNDER_IDX  = 1;
    localparam int WATT_OVER_IDX   = 0;

    typedef struct packed {
        logic [15:0] sense_diff_value;
        logic [15:0] bus_volt_value;
    } pmra_conv_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CURR,
        ST_POWR,
        ST_DONE
    } pmra_state_t;

endpackage : pmra_pkg

// ---- rtl/pmra_regs.sv ----
// Result, calibration, limit and alert mask registers with alert output
`timescale 1ns/1ps
module pmra_regs (
    input  wire logic               ref_clk_in,    // 125 MHz clock
    input  wire logic               reset_in,      // Sync reset, high
    input  wire logic [7:0]         reg_addr_in,   // Register pointer
    input  wire logic               reg_wr_in,     // Write strobe
    input  wire logic [15:0]        reg_wdata_in,  // Write data
    input  wire logic               reg_rd_in,     // Read strobe
    output logic      [15:0]        reg_rdata_out, // Read data
    input  wire logic               cfg_wr_in,     // Config reg written
    input  wire pmra_pkg::pmra_conv_t conv_in,     // Averaged results
    input  wire logic               conv_valid_in, // Results valid
    output logic                    conv_ready_out,// Math pipe idle
    output logic                    alert_out,     // Alert pin level
    output logic                    alert_oe_out   // Alert pin enable
);

////////////////////////////////////////////////////////////////////////////////

    pmra_pkg::pmra_state_t state_reg;
    pmra_pkg::pmra_state_t state_next;

    logic [15:0] shunt_reg;
    logic [15:0] bus_reg;
    logic [15:0] curr_reg;
    logic [15:0] pow_reg;
    logic [14:0] cal_reg;
    logic [15:0] limit_reg;
    logic [4:0]  lim_en_reg;
    logic        done_to_alert_enable_reg;
    logic        alert_source_flag_reg;
    logic        alert_source_flag_next;
    logic        conversion_done_flag_reg;
    logic        conversion_done_flag_next;
    logic        ovf_reg;
    logic        alert_sense_select_reg;
    logic        alert_hold_select_reg;
    logic [15:0] rdata_reg;
    logic        alert_reg;
    logic        alert_oe_reg;

    // Keeps only the top enable so one comparison ever drives the alert
    function automatic logic [4:0] prio_pick(input logic [4:0] req);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (req[i]) begin
                res = 5'h00;
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction : prio_pick

////////////////////////////////////////////////////////////////////////////////
// Decode

    wire wr_cal   = reg_wr_in && (reg_addr_in == pmra_pkg::ADDR_CAL);
    wire wr_mask  = reg_wr_in && (reg_addr_in == pmra_pkg::ADDR_MASK);
    wire wr_limit = reg_wr_in && (reg_addr_in == pmra_pkg::ADDR_LIMIT);
    wire rd_mask  = reg_rd_in && (reg_addr_in == pmra_pkg::ADDR_MASK);

    wire [4:0] lim_req = reg_wdata_in[pmra_pkg::LIM_HI:pmra_pkg::LIM_LO];
    wire [4:0] lim_won = prio_pick(lim_req);
    wire wr_done_alert = reg_wdata_in[pmra_pkg::DONE_ALERT_BIT];
    wire wr_sense_sel  = reg_wdata_in[pmra_pkg::SENSE_SEL_BIT];
    wire wr_hold_sel   = reg_wdata_in[pmra_pkg::HOLD_SEL_BIT];

    // Bits 9..5 are reserved and read as zero
    wire [15:0] mask_word = {lim_en_reg, done_to_alert_enable_reg, 5'h00,
                             alert_source_flag_reg, conversion_done_flag_reg,
                             ovf_reg, alert_sense_select_reg,
                             alert_hold_select_reg};

    wire [15:0] rd_mux =
        (reg_addr_in == pmra_pkg::ADDR_BUS)     ? bus_reg :
        (reg_addr_in == pmra_pkg::ADDR_POWER)   ? pow_reg :
        (reg_addr_in == pmra_pkg::ADDR_CURRENT) ? curr_reg :
        (reg_addr_in == pmra_pkg::ADDR_CAL)     ? {1'b0, cal_reg} :
        (reg_addr_in == pmra_pkg::ADDR_MASK)    ? mask_word :
        (reg_addr_in == pmra_pkg::ADDR_LIMIT)   ? limit_reg :
                                                  pmra_pkg::RESET_WORD;

////////////////////////////////////////////////////////////////////////////////
// Arithmetic

    // Signed shunt times unsigned calibration; no scaling shift applied
    wire signed [31:0] cur_prod =
        $signed(shunt_reg) * $signed({1'b0, cal_reg});
    wire        cur_ovf  = (cur_prod[31:15] != {17{cur_prod[15]}});
    wire [15:0] cur_mag  = curr_reg[15] ? 16'(-curr_reg) : curr_reg;
    wire [31:0] pow_prod = cur_mag * bus_reg;
    wire        pow_ovf  = (pow_prod[31:16] != 16'h0000);

////////////////////////////////////////////////////////////////////////////////
// Limit comparison

    wire shunt_over = $signed(shunt_reg) > $signed(limit_reg);
    wire shunt_undr = $signed(shunt_reg) < $signed(limit_reg);
    wire bus_over   = bus_reg > limit_reg;
    wire bus_undr   = bus_reg < limit_reg;
    wire pow_over   = pow_reg > limit_reg;

    wire fault_hit =
        (lim_en_reg[pmra_pkg::SENSE_OVER_IDX] && shunt_over) ||
        (lim_en_reg[pmra_pkg::SENSE_UNDER_IDX] && shunt_undr) ||
        (lim_en_reg[pmra_pkg::RAIL_OVER_IDX] && bus_over) ||
        (lim_en_reg[pmra_pkg::RAIL_UNDER_IDX] && bus_undr) ||
        (lim_en_reg[pmra_pkg::WATT_OVER_IDX] && pow_over);

    wire done_now   = (state_reg == pmra_pkg::ST_DONE);
    wire done_alert =
        done_to_alert_enable_reg && conversion_done_flag_reg;
    wire alert_act  = alert_source_flag_reg || done_alert;

////////////////////////////////////////////////////////////////////////////////
// Flags: a set in the same cycle as a clear wins

    always_comb begin
        conversion_done_flag_next = conversion_done_flag_reg;
        if (done_now) begin
            conversion_done_flag_next = 1'b1;
        end else if (rd_mask || cfg_wr_in) begin
            conversion_done_flag_next = 1'b0;
        end
        // A read in the finishing cycle still clears faults already seen
        alert_source_flag_next = alert_source_flag_reg;
        if (done_now && alert_hold_select_reg) begin
            alert_source_flag_next = fault_hit ||
                (alert_source_flag_reg && !rd_mask);
        end else if (done_now) begin
            alert_source_flag_next = fault_hit;
        end else if (rd_mask && alert_hold_select_reg) begin
            alert_source_flag_next = 1'b0;
        end
    end

    always_comb begin
        case (state_reg)
            pmra_pkg::ST_IDLE:
                state_next = conv_valid_in ? pmra_pkg::ST_CURR
                                           : pmra_pkg::ST_IDLE;
            pmra_pkg::ST_CURR: state_next = pmra_pkg::ST_POWR;
            pmra_pkg::ST_POWR: state_next = pmra_pkg::ST_DONE;
            pmra_pkg::ST_DONE: state_next = pmra_pkg::ST_IDLE;
            default:           state_next = pmra_pkg::ST_IDLE;
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// Math pipeline

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_reg <= pmra_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Results are overwritten only by a new averaged set from the front end
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            shunt_reg <= pmra_pkg::RESET_WORD;
            bus_reg   <= pmra_pkg::RESET_WORD;
        end else if (state_reg == pmra_pkg::ST_IDLE && conv_valid_in) begin
            shunt_reg <= conv_in.sense_diff_value;
            bus_reg   <= {1'b0, conv_in.bus_volt_value[14:0]};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            curr_reg <= pmra_pkg::RESET_WORD;
            pow_reg  <= pmra_pkg::RESET_WORD;
            ovf_reg  <= 1'b0;
        end else if (state_reg == pmra_pkg::ST_CURR) begin
            curr_reg <= cur_prod[15:0];
            ovf_reg  <= cur_ovf;
        end else if (state_reg == pmra_pkg::ST_POWR) begin
            pow_reg  <= pow_prod[15:0];
            ovf_reg  <= ovf_reg || pow_ovf;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Software registers

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cal_reg   <= pmra_pkg::CAL_RESET;
            limit_reg <= pmra_pkg::RESET_WORD;
        end else begin
            if (wr_cal) begin
                cal_reg <= reg_wdata_in[14:0];
            end
            if (wr_limit) begin
                limit_reg <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            lim_en_reg               <= pmra_pkg::LIM_RESET;
            done_to_alert_enable_reg <= 1'b0;
            alert_sense_select_reg   <= 1'b0;
            alert_hold_select_reg    <= 1'b0;
        end else if (wr_mask) begin
            lim_en_reg               <= lim_won;
            done_to_alert_enable_reg <= wr_done_alert;
            alert_sense_select_reg   <= wr_sense_sel;
            alert_hold_select_reg    <= wr_hold_sel;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            conversion_done_flag_reg <= 1'b0;
            alert_source_flag_reg    <= 1'b0;
            rdata_reg                <= pmra_pkg::RESET_WORD;
        end else begin
            conversion_done_flag_reg <= conversion_done_flag_next;
            alert_source_flag_reg    <= alert_source_flag_next;
            if (reg_rd_in) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // Open drain sinks only while active; inverted sense drives both levels
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            alert_reg    <= 1'b0;
            alert_oe_reg <= 1'b0;
        end else begin
            alert_reg    <= alert_sense_select_reg && alert_act;
            alert_oe_reg <= alert_sense_select_reg || alert_act;
        end
    end

    assign reg_rdata_out  = rdata_reg;
    assign alert_out      = alert_reg;
    assign alert_oe_out   = alert_oe_reg;
    assign conv_ready_out = (state_reg == pmra_pkg::ST_IDLE);

////////////////////////////////////////////////////////////////////////////////
// Checks

    bus_top_zero_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        reg_rd_in && reg_addr_in == pmra_pkg::ADDR_BUS
            |=> !reg_rdata_out[15])
        else $error("bus voltage read shows bit 15 set");

    avg_capture_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        state_reg == pmra_pkg::ST_IDLE && conv_valid_in
            |=> shunt_reg == $past(conv_in.sense_diff_value)
                ##3 conv_ready_out)
        else $error("averaged result not captured or pipe stuck");

    power_calc_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        done_now |-> pow_reg == pow_prod[15:0])
        else $error("power result does not match current times bus");

    current_calc_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        state_reg == pmra_pkg::ST_CURR && !wr_cal
            |=> curr_reg == cur_prod[15:0])
        else $error("current result does not match shunt times cal");

    cal_top_zero_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        reg_rd_in && reg_addr_in == pmra_pkg::ADDR_CAL
            |=> !reg_rdata_out[15])
        else $error("calibration read shows bit 15 set");

    sense_over_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        done_now && lim_en_reg[pmra_pkg::SENSE_OVER_IDX] && shunt_over
            |=> alert_source_flag_reg)
        else $error("shunt over limit did not raise alert flag");

    one_limit_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        wr_mask && reg_wdata_in[pmra_pkg::LIM_HI]
            |=> lim_en_reg == 5'h10 ##1 $onehot0(lim_en_reg))
        else $error("limit enable priority not applied");

    done_flag_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        (done_now |=> conversion_done_flag_reg) and
        (rd_mask && !done_now |=> !conversion_done_flag_reg))
        else $error("conversion done flag set or clear wrong");

    latch_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        alert_hold_select_reg && alert_source_flag_reg && !rd_mask && !wr_mask
            |=> alert_source_flag_reg)
        else $error("latched alert flag dropped without a read");

    alert_sense_a: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        done_alert && !alert_sense_select_reg &&
        $stable(alert_sense_select_reg)
            |=> alert_oe_out && !alert_out)
        else $error("done flag did not pull the alert low");

endmodule : pmra_regs

// ---- verification/pmra_host_model.sv ----
// Register host model standing in for the serial engine
`timescale 1ns/1ps
module pmra_host_model (
    input  wire logic        ref_clk_in,    // Bench clock
    output logic      [7:0]  reg_addr_out,  // Register pointer
    output logic             reg_wr_out,    // Write strobe
    output logic      [15:0] reg_wdata_out, // Write data
    output logic             reg_rd_out,    // Read strobe
    input  wire logic [15:0] reg_rdata_in   // Read data
);
    initial begin
        reg_addr_out  = 8'h00;
        reg_wr_out    = 1'b0;
        reg_wdata_out = 16'h0000;
        reg_rd_out    = 1'b0;
    end
    // Whole words only; byte pairing happens before this port
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk_in);
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_wr_out    = 1'b1;
        @(negedge ref_clk_in);
        reg_wr_out    = 1'b0;
        // Released data must not keep showing the last word
        reg_wdata_out = ~d;
    endtask : write_word
    task automatic read_word(input logic [7:0] a, output logic [15:0] d);
        @(negedge ref_clk_in);
        reg_addr_out = a;
        reg_rd_out   = 1'b1;
        @(negedge ref_clk_in);
        reg_rd_out   = 1'b0;
        d            = reg_rdata_in;
    endtask : read_word
endmodule : pmra_host_model

// ---- verification/tb_power_monitor_result_alert_regs.sv ----
// Self-checking bench for the result and alert register block
`timescale 1ns/1ps
module tb_power_monitor_result_alert_regs;
    logic                 ref_clk_in    = 1'b0;
    logic                 reset_in      = 1'b1;
    logic                 cfg_wr_in     = 1'b0;
    logic                 conv_valid_in = 1'b0;
    pmra_pkg::pmra_conv_t conv_in       = '0;
    logic [7:0]           reg_addr;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [15:0]          reg_wdata;
    logic [15:0]          reg_rdata;
    logic                 conv_ready_out;
    logic                 alert_out;
    logic                 alert_oe_out;
    logic [15:0]          rd_val;
    int                   fails    = 0;
    int                   compares = 0;
    // Mask, limit, shunt, bus, expected flag
    logic [64:0] tbl [8] = '{
        {16'h4000, 16'h0000, 16'hfff0, 16'h0010, 1'b1},
        {16'h2000, 16'h0100, 16'h0001, 16'h0200, 1'b1},
        {16'h1000, 16'h0100, 16'h0001, 16'h0050, 1'b1},
        {16'h0800, 16'h0010, 16'h0010, 16'h0002, 1'b1},
        {16'h8000, 16'h0020, 16'h0020, 16'h0010, 1'b0},
        {16'h6000, 16'h0000, 16'h0010, 16'h0010, 1'b0},
        {16'h3000, 16'h0100, 16'h0001, 16'h0050, 1'b0},
        {16'h1800, 16'h0100, 16'h0001, 16'h0200, 1'b0}};

    always #4 ref_clk_in = ~ref_clk_in;

    pmra_host_model host (
        .ref_clk_in   (ref_clk_in),
        .reg_addr_out (reg_addr),
        .reg_wr_out   (reg_wr),
        .reg_wdata_out(reg_wdata),
        .reg_rd_out   (reg_rd),
        .reg_rdata_in (reg_rdata)
    );

    pmra_regs dut (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .reg_addr_in   (reg_addr),
        .reg_wr_in     (reg_wr),
        .reg_wdata_in  (reg_wdata),
        .reg_rd_in     (reg_rd),
        .reg_rdata_out (reg_rdata),
        .cfg_wr_in     (cfg_wr_in),
        .conv_in       (conv_in),
        .conv_valid_in (conv_valid_in),
        .conv_ready_out(conv_ready_out),
        .alert_out     (alert_out),
        .alert_oe_out  (alert_oe_out)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check16(string nm, logic [15:0] e, logic [15:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check16
    task automatic check1(string nm, logic e, logic s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", nm, e, s);
        end
    endtask : check1
    task automatic rd_chk(logic [7:0] a, logic [15:0] e, string nm);
        host.read_word(a, rd_val);
        check16(nm, e, rd_val);
    endtask : rd_chk
    // Waits until the alert pins have followed the new flags
    task automatic convert(logic [15:0] sh, logic [15:0] bus);
        @(negedge ref_clk_in);
        conv_in       = {sh, bus};
        conv_valid_in = 1'b1;
        @(negedge ref_clk_in);
        conv_valid_in = 1'b0;
        conv_in       = ~conv_in;
        check1("ready while busy", 1'b0, conv_ready_out);
        repeat (5) @(negedge ref_clk_in);
    endtask : convert
    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fails++;
        print_verdict();
    end

    initial begin
        repeat (4) @(negedge ref_clk_in);
        reset_in = 1'b0;
        for (int a = 2; a <= 8; a++) begin
            rd_chk(a[7:0], 16'h0000, "reset word");
        end
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            host.write_word(8'h06, (16'hf800 >> i) & 16'hf800);
            rd_chk(8'h06, 16'h8000 >> i, "kept enable");
        end
        $display("test enable priority done");
        host.write_word(8'h06, 16'h0000);
        host.write_word(8'h05, 16'hffff);
        rd_chk(8'h05, 16'h7fff, "calibration");
        host.write_word(8'h03, 16'h1234);
        rd_chk(8'h03, 16'h0000, "power read only");
        host.write_word(8'h05, 16'h0003);
        convert(16'h0010, 16'h8005);
        rd_chk(8'h02, 16'h0005, "bus result");
        rd_chk(8'h04, 16'h0030, "current");
        rd_chk(8'h03, 16'h00f0, "power");
        host.write_word(8'h05, 16'h0007);
        convert(16'hfffe, 16'h0005);
        rd_chk(8'h04, 16'hfff2, "signed current");
        rd_chk(8'h03, 16'h0046, "unsigned power");
        $display("test results done");
        host.write_word(8'h05, 16'h0001);
        foreach (tbl[i]) begin
            host.write_word(8'h06, tbl[i][64:49]);
            host.write_word(8'h07, tbl[i][48:33]);
            convert(tbl[i][32:17], tbl[i][16:1]);
            check1("alert enable", tbl[i][0], alert_oe_out);
            host.read_word(8'h06, rd_val);
            check1("source flag", tbl[i][0], rd_val[4]);
        end
        $display("test limit functions done");
        host.write_word(8'h06, 16'h8003);
        host.write_word(8'h07, 16'h0020);
        convert(16'h0030, 16'h0010);
        check1("alert high", 1'b1, alert_out);
        convert(16'h0010, 16'h0010);
        check1("alert held", 1'b1, alert_out);
        rd_chk(8'h06, 16'h801b, "latched mask");
        @(negedge ref_clk_in);
        check1("alert after read", 1'b0, alert_out);
        host.write_word(8'h06, 16'h8002);
        convert(16'h0030, 16'h0010);
        check1("alert follows", 1'b1, alert_out);
        convert(16'h0010, 16'h0010);
        check1("alert idle", 1'b0, alert_out);
        $display("test alert modes done");
        host.write_word(8'h06, 16'h0400);
        convert(16'h0010, 16'h0010);
        check1("done enable", 1'b1, alert_oe_out);
        check1("done level", 1'b0, alert_out);
        @(negedge ref_clk_in);
        cfg_wr_in = 1'b1;
        @(negedge ref_clk_in);
        cfg_wr_in = 1'b0;
        @(negedge ref_clk_in);
        check1("after config", 1'b0, alert_oe_out);
        convert(16'h0010, 16'h0010);
        rd_chk(8'h06, 16'h0408, "done flag");
        @(negedge ref_clk_in);
        check1("after mask read", 1'b0, alert_oe_out);
        $display("test done flag done");
        print_verdict();
    end
endmodule : tb_power_monitor_result_alert_regs
